// ### rtl/dppa_pkg.sv
package dppa_pkg;

   typedef logic [7:0] dppa_byte_t;

   // Register reached by the current bus address.
   typedef enum logic [2:0]
   {
      DPPA_SEL_NONE,
      DPPA_SEL_A_PORT,
      DPPA_SEL_A_DIR,
      DPPA_SEL_A_CTRL,
      DPPA_SEL_B_PORT,
      DPPA_SEL_B_DIR,
      DPPA_SEL_B_CTRL
   } dppa_sel_e;

endpackage

// ### rtl/dppa_regs.svh
`ifndef DPPA_REGS_SVH
`define DPPA_REGS_SVH

// ============================================================
// Register select codes, {reg_sel_hi, reg_sel_lo}
`define DPPA_RS_A_DATA      2'h0
`define DPPA_RS_A_CTRL      2'h1
`define DPPA_RS_B_DATA      2'h2
`define DPPA_RS_B_CTRL      2'h3

// ============================================================
// Control register fields
`define DPPA_CR_EDGE1_EN    0
`define DPPA_CR_EDGE1_POL   1
`define DPPA_CR_DIR_ACCESS  2
`define DPPA_CR_EDGE2_EN    3
`define DPPA_CR_EDGE2_POL   4
`define DPPA_CR_LINE2_OUT   5
`define DPPA_CR_FLAG2       6
`define DPPA_CR_FLAG1       7

// ============================================================
// Reset values
`define DPPA_CTRL_RESET     8'h00
`define DPPA_DIR_RESET      8'h00
`define DPPA_OUT_RESET      8'h00

// ============================================================
// Synchroniser depth in clk_sys cycles before logic sees a pin
`define DPPA_SYNC_DEPTH     2

`endif

// ### rtl/dppa_sync.sv
`timescale 1ns/1ps

// ============================================================
// Two-stage synchroniser with edge detection on the safe stage.
module dppa_sync
#(
   parameter int W = 1
)
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // Asynchronous inputs
   input  wire logic [W-1:0] async_in,
   // Synchronised level and one-cycle edge pulses
   output logic [W-1:0]      level,
   output logic [W-1:0]      rise,
   output logic [W-1:0]      fall
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edges are taken only from the second stage; the first may be metastable.
   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;

endmodule // dppa_sync

// ### rtl/dppa_top.sv
`timescale 1ns/1ps
`include "dppa_regs.svh"

module dppa_top
   import dppa_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       reset_n,

   // Processor bus
   input  wire logic       phi2,
   input  wire logic       rw,
   input  wire logic       chip_sel_pos_first,
   input  wire logic       chip_sel_pos_second,
   input  wire logic       chip_sel_neg_n,
   input  wire logic       reg_sel_lo,
   input  wire logic       reg_sel_hi,
   input  wire logic [7:0] data_in,
   output logic [7:0]      data_out,
   output logic            data_oe,

   // Side A peripheral
   input  wire logic [7:0] side_a_pins_in,
   output logic [7:0]      side_a_pins_out,
   output logic [7:0]      side_a_pins_oe,
   input  wire logic       side_a_edge_in,
   input  wire logic       side_a_ctl_line,
   output logic            side_a_int_n_out,
   output logic            side_a_int_n_oe,

   // Side B peripheral
   input  wire logic [7:0] side_b_pins_in,
   output logic [7:0]      side_b_pins_out,
   output logic [7:0]      side_b_pins_oe,
   input  wire logic       side_b_edge_in,
   input  wire logic       side_b_ctl_line,
   output logic            side_b_int_n_out,
   output logic            side_b_int_n_oe
);

   localparam int SYNC_W = 36;

   // ============================================================
   // Input synchronisation
   logic [SYNC_W-1:0] sync_raw;
   logic [SYNC_W-1:0] sync_lvl;
   logic [SYNC_W-1:0] sync_rise;
   logic [SYNC_W-1:0] sync_fall;

   assign sync_raw = {reset_n, phi2, rw, chip_sel_pos_first,
                      chip_sel_pos_second, chip_sel_neg_n, reg_sel_hi,
                      reg_sel_lo, data_in, side_a_pins_in, side_b_pins_in,
                      side_a_edge_in, side_a_ctl_line, side_b_edge_in,
                      side_b_ctl_line};

   dppa_sync
   #(
      .W(SYNC_W)
   )
   u_sync
   (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (sync_raw),
      .level    (sync_lvl),
      .rise     (sync_rise),
      .fall     (sync_fall)
   );

   wire             reset_n_s  = sync_lvl[35];
   wire             phi2_s     = sync_lvl[34];
   wire             phi2_fall  = sync_fall[34];
   wire             rw_s       = sync_lvl[33];
   wire             cs0_s      = sync_lvl[32];
   wire             cs1_s      = sync_lvl[31];
   wire             cs2_n_s    = sync_lvl[30];
   wire [1:0]       rs_s       = sync_lvl[29:28];
   wire dppa_byte_t data_s     = sync_lvl[27:20];

   // Per-side views, index 0 is side A and index 1 is side B.
   logic [1:0][7:0] pins_s;
   logic [1:0]      edge1_rise;
   logic [1:0]      edge1_fall;
   logic [1:0]      edge2_rise;
   logic [1:0]      edge2_fall;

   assign pins_s[0]     = sync_lvl[19:12];
   assign pins_s[1]     = sync_lvl[11:4];
   assign edge1_rise[0] = sync_rise[3];
   assign edge1_fall[0] = sync_fall[3];
   assign edge2_rise[0] = sync_rise[2];
   assign edge2_fall[0] = sync_fall[2];
   assign edge1_rise[1] = sync_rise[1];
   assign edge1_fall[1] = sync_fall[1];
   assign edge2_rise[1] = sync_rise[0];
   assign edge2_fall[1] = sync_fall[0];

   // The reset pin clears the registers like the system reset.
   wire clear = rst | ~reset_n_s;

   // ============================================================
   // Register state
   // Unpacked so that each side's clocked process owns its own element.
   logic [7:0]      ctrl_q [0:1];
   logic [1:0][7:0] ctrl_d;
   logic [7:0]      dir_q  [0:1];
   logic [7:0]      out_q  [0:1];
   logic            int_q  [0:1];
   logic [1:0][7:0] port_rd;

   // ============================================================
   // Address decode
   wire chip_ok = cs0_s & cs1_s & ~cs2_n_s;

   wire dppa_sel_e sel_now =
      !chip_ok ? DPPA_SEL_NONE :
      (rs_s == `DPPA_RS_A_DATA) ?
         (ctrl_q[0][`DPPA_CR_DIR_ACCESS] ? DPPA_SEL_A_PORT
                                         : DPPA_SEL_A_DIR) :
      (rs_s == `DPPA_RS_A_CTRL) ? DPPA_SEL_A_CTRL :
      (rs_s == `DPPA_RS_B_DATA) ?
         (ctrl_q[1][`DPPA_CR_DIR_ACCESS] ? DPPA_SEL_B_PORT
                                         : DPPA_SEL_B_DIR) :
      DPPA_SEL_B_CTRL;

   // ============================================================
   // Read path
   wire dppa_byte_t rd_mux =
      (sel_now == DPPA_SEL_A_PORT) ? port_rd[0] :
      (sel_now == DPPA_SEL_A_DIR)  ? dir_q[0]   :
      (sel_now == DPPA_SEL_A_CTRL) ? ctrl_q[0]  :
      (sel_now == DPPA_SEL_B_PORT) ? port_rd[1] :
      (sel_now == DPPA_SEL_B_DIR)  ? dir_q[1]   :
      (sel_now == DPPA_SEL_B_CTRL) ? ctrl_q[1]  :
      8'h00;

   // Side A reads the pins themselves, so a loaded output reads as it is.
   assign port_rd[0] = pins_s[0];

   // Side B reads its register for outputs and the pin for inputs.
   assign port_rd[1] = (out_q[1] & dir_q[1]) |
                       (pins_s[1] & ~dir_q[1]);

   logic [7:0] dout_q;
   logic       doe_q;

   always_ff @(posedge clk_sys)
   begin
      if (clear)
      begin
         dout_q <= 8'h00;
         doe_q  <= 1'b0;
      end
      else
      begin
         dout_q <= rd_mux;
         doe_q  <= phi2_s & rw_s & (sel_now != DPPA_SEL_NONE);
      end
   end

   // ============================================================
   // Bus latch: address, direction and data sampled during the pulse and held after it
   dppa_sel_e  lat_sel_q;
   logic       lat_rw_q;
   dppa_byte_t lat_data_q;

   always_ff @(posedge clk_sys)
   begin
      if (clear)
      begin
         lat_sel_q  <= DPPA_SEL_NONE;
         lat_rw_q   <= 1'b1;
         lat_data_q <= 8'h00;
      end
      else if (phi2_s)
      begin
         lat_sel_q  <= sel_now;
         lat_rw_q   <= rw_s;
         lat_data_q <= data_s;
      end
   end

   // Actions fire once, on the trailing edge of the bus pulse. Committing
   // there rather than during the pulse keeps the port lines from
   // glitching while the data bus is still settling.
   wire do_wr = phi2_fall & ~lat_rw_q;
   wire do_rd = phi2_fall & lat_rw_q;

   logic [1:0] wr_port;
   logic [1:0] wr_dir;
   logic [1:0] wr_ctrl;
   logic [1:0] rd_clr;

   assign wr_port[0] = do_wr & (lat_sel_q == DPPA_SEL_A_PORT);
   assign wr_dir[0]  = do_wr & (lat_sel_q == DPPA_SEL_A_DIR);
   assign wr_ctrl[0] = do_wr & (lat_sel_q == DPPA_SEL_A_CTRL);
   assign rd_clr[0]  = do_rd & (lat_sel_q == DPPA_SEL_A_PORT);
   assign wr_port[1] = do_wr & (lat_sel_q == DPPA_SEL_B_PORT);
   assign wr_dir[1]  = do_wr & (lat_sel_q == DPPA_SEL_B_DIR);
   assign wr_ctrl[1] = do_wr & (lat_sel_q == DPPA_SEL_B_CTRL);
   assign rd_clr[1]  = do_rd & (lat_sel_q == DPPA_SEL_B_PORT);

   // ============================================================
   // Per-side registers, flags and interrupt
   genvar s;
   generate
      for (s = 0; s < 2; s++)
      begin : g_side
         wire edge1 = ctrl_q[s][`DPPA_CR_EDGE1_POL] ? edge1_rise[s]
                                                    : edge1_fall[s];
         wire edge2 = ~ctrl_q[s][`DPPA_CR_LINE2_OUT] &
                      (ctrl_q[s][`DPPA_CR_EDGE2_POL] ? edge2_rise[s]
                                                     : edge2_fall[s]);

         // An edge in the same cycle as the clearing read still sets.
         wire flag1_d = edge1 |
                        (ctrl_q[s][`DPPA_CR_FLAG1] & ~rd_clr[s]);
         wire flag2_d = edge2 |
                        (ctrl_q[s][`DPPA_CR_FLAG2] & ~rd_clr[s]);

         // Writes reach only the low six bits; the flags stay intact.
         assign ctrl_d[s] = {flag1_d, flag2_d,
                             wr_ctrl[s] ? lat_data_q[5:0]
                                        : ctrl_q[s][5:0]};

         always_ff @(posedge clk_sys)
         begin
            if (clear)
            begin
               ctrl_q[s] <= `DPPA_CTRL_RESET;
               dir_q[s]  <= `DPPA_DIR_RESET;
               out_q[s]  <= `DPPA_OUT_RESET;
               int_q[s]  <= 1'b0;
            end
            else
            begin
               ctrl_q[s] <= ctrl_d[s];
               if (wr_dir[s])
                  dir_q[s] <= lat_data_q;
               if (wr_port[s])
                  out_q[s] <= lat_data_q;
               int_q[s] <= (ctrl_q[s][`DPPA_CR_FLAG1] &
                            ctrl_q[s][`DPPA_CR_EDGE1_EN]) |
                           (ctrl_q[s][`DPPA_CR_FLAG2] &
                            ctrl_q[s][`DPPA_CR_EDGE2_EN]);
            end
         end
      end
   endgenerate

   // ============================================================
   // Outputs
   // Pins follow the output register only where the direction bit is 1;
   // elsewhere the driver is off and the pin takes the outside level.
   assign side_a_pins_out = out_q[0];
   assign side_a_pins_oe  = dir_q[0];
   assign side_b_pins_out = out_q[1];
   assign side_b_pins_oe  = dir_q[1];

   // Open-drain request lines only ever pull low.
   logic int_low_q;

   always_ff @(posedge clk_sys)
   begin
      int_low_q <= 1'b0;
   end

   assign side_a_int_n_out = int_low_q;
   assign side_a_int_n_oe  = int_q[0];
   assign side_b_int_n_out = int_low_q;
   assign side_b_int_n_oe  = int_q[1];

   assign data_out = dout_q;
   assign data_oe  = doe_q;

endmodule // dppa_top

// ### tb/dppa_checker.sv
`timescale 1ns/1ps

module dppa_checker
(
   // Clock and resets
   input logic       clk_sys,
   input logic       rst,
   input logic       reset_n,
   // Processor bus
   input logic       phi2,
   input logic       rw,
   input logic       chip_sel_pos_first,
   input logic       chip_sel_pos_second,
   input logic       chip_sel_neg_n,
   input logic       reg_sel_lo,
   input logic       reg_sel_hi,
   input logic       data_oe,
   // Peripheral sides
   input logic [7:0] side_a_pins_out,
   input logic [7:0] side_b_pins_oe,
   input logic       side_a_edge_in,
   input logic       side_a_ctl_line,
   input logic       side_a_int_n_oe,
   input logic       side_a_int_n_out,
   input logic       side_b_int_n_out
);
   // ==========
   // Helpers
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire sel = chip_sel_pos_first & chip_sel_pos_second & ~chip_sel_neg_n;
   // The pin reset is seen late through its synchroniser, so any low
   // sample in the last four cycles excuses a register clear.
   logic [3:0] rn_q;
   always_ff @(posedge clk_sys)
      rn_q <= {rn_q[2:0], reset_n};
   wire rn_low = ~&rn_q;

   sequence rd_req;
      (phi2 && rw && sel)[*5];
   endsequence
   sequence phi2_end;
      phi2 ##1 !phi2;
   endsequence

   // ==========
   // Properties
   bus_drive_a: assert property (data_oe |-> $past(sel && rw, 3))
      else $error("data bus driven without a selected read");
   rd_drive_a: assert property (rd_req |-> data_oe)
      else $error("selected read not driven");
   drive_end_a: assert property (phi2_end |-> ##4 !data_oe)
      else $error("data bus still driven after strobe");
   int_level_a: assert property (!side_a_int_n_out && !side_b_int_n_out)
      else $error("interrupt line drives high");
   a_out_wr_a: assert property ($changed(side_a_pins_out) |-> rn_low ||
      $past(sel && !rw && !reg_sel_hi && !reg_sel_lo, 3))
      else $error("side a output changed without write");
   b_dir_wr_a: assert property ($changed(side_b_pins_oe) |-> rn_low ||
      $past(sel && !rw && reg_sel_hi && !reg_sel_lo, 3))
      else $error("side b direction changed without write");
   int_rise_a: assert property ($rose(side_a_int_n_oe) |->
      ($past(side_a_edge_in, 2) ^ $past(side_a_edge_in, 7)) ||
      ($past(side_a_ctl_line, 2) ^ $past(side_a_ctl_line, 7)) ||
      $past(sel && !rw, 3))
      else $error("side a interrupt without edge");
   int_fall_a: assert property ($fell(side_a_int_n_oe) |->
      $past(sel, 3) || rn_low)
      else $error("side a interrupt dropped without access");
endmodule // dppa_checker

bind dppa_top dppa_checker chk (.*);

// ### tb/dppa_cpu.sv
`timescale 1ns/1ps

module dppa_cpu
   import dppa_pkg::*;
(
   // Clock and read data
   input logic       clk_sys,
   input dppa_byte_t data_out,
   // Bus drive
   output logic      phi2,
   output logic      rw,
   output logic      chip_sel_pos_first,
   output logic      chip_sel_pos_second,
   output logic      chip_sel_neg_n,
   output logic      reg_sel_lo,
   output logic      reg_sel_hi,
   output dppa_byte_t data_in
);
   initial
   begin
      {phi2, rw, chip_sel_pos_first, chip_sel_pos_second} = 4'h4;
      {chip_sel_neg_n, reg_sel_hi, reg_sel_lo} = 3'h4;
      data_in = 8'hA5;
   end

   // Phi2 stays long against the sampling clock, and every qualifier is
   // held until the device has seen the strobe fall.
   task automatic access(input logic wr, input logic [1:0] rs,
                         input dppa_byte_t d, input logic sel,
                         output dppa_byte_t q);
      @(negedge clk_sys);
      {rw, reg_sel_hi, reg_sel_lo} = {~wr, rs};
      {chip_sel_pos_first, chip_sel_pos_second, chip_sel_neg_n} = {sel, 2'h2};
      data_in = d;
      phi2 = 1'b1;
      repeat (6) @(negedge clk_sys);
      q = data_out;
      phi2 = 1'b0;
      repeat (3) @(negedge clk_sys);
      chip_sel_pos_first = 1'b0;
      // A released bus does not keep its last value.
      data_in = ~d;
      repeat (3) @(negedge clk_sys);
   endtask
endmodule // dppa_cpu

// ### tb/dual_port_peripheral_adapter_tb.sv
`timescale 1ns/1ps

module dual_port_peripheral_adapter_tb
   import dppa_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1, reset_n = 1'b1;
   logic phi2, rw, chip_sel_pos_first, chip_sel_pos_second, chip_sel_neg_n;
   logic reg_sel_lo, reg_sel_hi, data_oe, s, p, e;
   logic side_a_edge_in = 1'b0, side_a_ctl_line = 1'b0;
   logic side_b_edge_in = 1'b0, side_b_ctl_line = 1'b0;
   logic side_a_int_n_out, side_a_int_n_oe, side_b_int_n_out, side_b_int_n_oe;
   dppa_byte_t data_in, data_out, side_a_pins_out, side_a_pins_oe;
   dppa_byte_t side_b_pins_out, side_b_pins_oe, q, cr, da, oa, db, ob;
   dppa_byte_t ext_a = 8'h00, ext_b = 8'h00, load = 8'h00;
   int fails = 0, cmp_count = 0, cyc = 0;
   // Loaded lines read low whatever drives them.
   wire dppa_byte_t side_a_pins_in = mix(side_a_pins_out, side_a_pins_oe,
                                         ext_a) & ~load;
   wire dppa_byte_t side_b_pins_in = mix(side_b_pins_out, side_b_pins_oe,
                                         ext_b) & ~load;
   wire int_oe = s ? side_b_int_n_oe : side_a_int_n_oe;

   dppa_top dut (.*);
   dppa_cpu cpu (.*);

   always #12.5 clk_sys = ~clk_sys;

   function automatic dppa_byte_t mix(input dppa_byte_t o, d, x);
      return (o & d) | (x & ~d);
   endfunction

   // ==========
   // Checking
   task automatic chk(input dppa_byte_t got, input dppa_byte_t want);
      cmp_count++;
      if (got !== want)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask

   task automatic wr(input logic [1:0] a, input dppa_byte_t d);
      cpu.access(1'b1, a, d, 1'b1, q);
   endtask

   task automatic rdc(input logic [1:0] a, input dppa_byte_t w);
      cpu.access(1'b0, a, 8'h00, 1'b1, q);
      chk(q, w);
   endtask

   task automatic lines(input logic v1, input logic v2);
      if (s)
         {side_b_edge_in, side_b_ctl_line} = {v1, v2};
      else
         {side_a_edge_in, side_a_ctl_line} = {v1, v2};
      repeat (6) @(negedge clk_sys);
   endtask

   task give_verdict;
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict;
      end
   end

   // ==========
   // Sequence
   initial
   begin
      void'($urandom(83937));
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 4; i++)
         rdc(2'(i), 8'h00);
      for (int n = 0; n < 8; n++)
      begin
         {da, oa, db, ob} = $urandom;
         {ext_a, ext_b, load} = 24'($urandom);
         if (n == 0)
            {da, oa, load} = 24'hFF_FF_81;
         wr(2'h1, 8'h00);
         wr(2'h3, 8'h00);
         wr(2'h0, da);
         wr(2'h2, db);
         wr(2'h1, 8'h04);
         wr(2'h3, 8'h04);
         wr(2'h0, oa);
         wr(2'h2, ob);
         cpu.access(1'b1, 2'h0, ~oa, 1'b0, q);
         chk(side_a_pins_out, oa);
         chk(side_a_pins_oe, da);
         chk(side_b_pins_out, ob);
         chk(side_b_pins_oe, db);
         rdc(2'h0, mix(oa, da, ext_a) & ~load);
         rdc(2'h2, mix(ob, db, ext_b & ~load));
         rdc(2'h1, 8'h04);
         wr(2'h1, 8'h00);
         rdc(2'h0, da);
      end
      reset_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(side_a_pins_oe | side_a_pins_out | side_b_pins_oe, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         {s, p, e} = 3'(k);
         cr = {3'h0, p, e, 1'b1, p, e};
         lines(~p, ~p);
         wr({s, 1'b1}, cr);
         cpu.access(1'b0, {s, 1'b0}, 8'h00, 1'b1, q);
         lines(p, ~p);
         rdc({s, 1'b1}, {2'h2, cr[5:0]});
         lines(p, p);
         rdc({s, 1'b1}, {2'h3, cr[5:0]});
         chk({7'h00, int_oe}, {7'h00, e});
         cpu.access(1'b0, {s, 1'b0}, 8'h00, 1'b1, q);
         chk({7'h00, int_oe}, 8'h00);
         lines(~p, ~p);
         wr({s, 1'b1}, cr | 8'hC0);
         rdc({s, 1'b1}, cr);
      end
      give_verdict;
   end
endmodule // dual_port_peripheral_adapter_tb
